// File: core/lane_read_steer.sv
`timescale 1ns/1ps
`default_nettype none
module lane_read_steer (
  input wire logic [3:0] be_n,
  input wire logic [31:0] word,
  output logic [31:0] lanes
);
  logic [7:0] b0, b1, b2, b3;
  always_comb begin
    b0 = word[7:0];
    b1 = word[15:8];
    b2 = word[23:16];
    b3 = word[31:24];
    if (!be_n[0]) begin
      lanes = {b3, b2, b1, b0};
    end else if (!be_n[1]) begin
      lanes = {b3, b2, b1, b1};
    end else if (!be_n[2]) begin
      lanes = {b3, b2, b3, b2};
    end else begin
      lanes = {b3, b3, b3, b3};
    end
  end
endmodule : lane_read_steer
`default_nettype wire

// File: core/passthru_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module passthru_fifo #(
  parameter int WIDTH = 71,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic full_reg, full_next;
  logic ready_reg;
  logic push, pop;

  always_comb begin
    push = in_valid && !full_reg;
    pop = out_ready && (count_reg != '0);
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    full_next = (count_next == (AW+1)'(DEPTH));
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      full_reg <= full_next;
      ready_reg <= !full_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  assign in_ready = ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
endmodule : passthru_fifo
`default_nettype wire

// File: core/passthru_lane_steer.sv
`timescale 1ns/1ps
`default_nettype none
module passthru_lane_steer #(
  parameter int DEPTH = passthru_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  // Boot load of region base registers
  input wire logic boot_valid,
  input wire logic [1:0] boot_index,
  input wire logic [31:0] boot_data,
  // PCI-side phase queue
  input wire logic phase_valid,
  output logic phase_ready,
  input wire logic phase_is_write,
  input wire logic [1:0] phase_region,
  input wire logic [3:0] phase_byte_enable_n,
  input wire logic [31:0] phase_address,
  input wire logic [31:0] phase_data,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [31:0] rsp_data,
  // Add-on pins
  input wire logic mode_16bit,
  input wire logic select_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic addr_word_sel,
  input wire logic addr_bit_one,
  input wire logic [3:0] addon_byte_enable_n,
  input wire logic pt_address_output_enable_n,
  input wire logic addon_ready_n,
  input wire logic [31:0] dq_in,
  output logic [31:0] dq_out,
  output logic [31:0] dq_oe,
  output logic access_attention_n,
  output logic [3:0] byte_pending_n,
  output logic pass_write,
  output logic [1:0] region_num,
  // Region status
  output logic [3:0] region_enabled,
  output logic [3:0] region_is_io,
  output logic [3:0] region_below_1m,
  output logic [3:0] region_prefetch
);
  localparam int ENTRY_W = 1 + 2 + 4 + 32 + 32;
  localparam int PIN_W = 1 + 1 + 1 + 1 + 1 + 4 + 1 + 1 + 32 + 1;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_ACTIVE} phase_state_t;

  function automatic logic [1:0] width_of(input logic [31:0] base);
    width_of = base[passthru_pkg::BASE_WIDTH_HI:passthru_pkg::BASE_WIDTH_LO];
  endfunction : width_of

  // Effective enables after the 16-bit half select
  function automatic logic [3:0] eff_enables(input logic mode16, input logic a1,
      input logic [3:0] be_n);
    eff_enables = be_n;
    if (mode16) begin
      eff_enables = be_n | (a1 ? 4'h3 : 4'hc);
    end
  endfunction : eff_enables

  // Output enable mask by bus mode
  function automatic logic [31:0] drive_mask(input logic mode16);
    drive_mask = mode16 ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction : drive_mask

  // Two-stage pin synchroniser
  // Only the second stage feeds logic
  logic [PIN_W-1:0] pin_raw, sync1_reg, sync2_reg;
  assign pin_raw = {mode_16bit, select_n, rd_n, wr_n, addr_word_sel, addon_byte_enable_n,
                    addr_bit_one, pt_address_output_enable_n, dq_in, addon_ready_n};
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic s_mode16, s_sel_n, s_rd_n, s_wr_n, s_addr_sel, s_a1, s_aoe_n, s_ready_n;
  logic [3:0] s_be_n;
  logic [31:0] s_dq;
  assign {s_mode16, s_sel_n, s_rd_n, s_wr_n, s_addr_sel, s_be_n, s_a1, s_aoe_n, s_dq,
          s_ready_n} = sync2_reg;

  // Phase queue
  logic [ENTRY_W-1:0] fifo_out;
  logic fifo_out_valid, fifo_pop;
  passthru_fifo #(.WIDTH(ENTRY_W), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(phase_valid),
    .in_ready(phase_ready),
    .in_data({phase_is_write, phase_region, phase_byte_enable_n, phase_address, phase_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // Region base registers
  logic [31:0] base_reg [passthru_pkg::REGION_CNT];
  logic [3:0] en_reg, en_next, io_reg, io_next, low_reg, low_next, pf_reg, pf_next;
  genvar gi;
  generate
    for (gi = 0; gi < passthru_pkg::REGION_CNT; gi++) begin : g_base
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          base_reg[gi] <= passthru_pkg::BASE_RESET;
        end else if (boot_valid && boot_index == 2'(gi)) begin
          base_reg[gi] <= boot_data;
        end
      end
      always_comb begin
        en_next[gi] = width_of(base_reg[gi]) != passthru_pkg::WIDTH_OFF;
        io_next[gi] = base_reg[gi][passthru_pkg::BASE_SPACE_BIT];
        low_next[gi] = !io_next[gi] && base_reg[gi][passthru_pkg::BASE_LOC_HI:
          passthru_pkg::BASE_LOC_LO] == passthru_pkg::LOC_BELOW_1M;
        pf_next[gi] = !io_next[gi] && base_reg[gi][passthru_pkg::BASE_PREFETCH_BIT];
      end
    end
  endgenerate

  // Phase state
  phase_state_t state_reg, state_next;
  logic [31:0] data_reg, data_next, addr_reg, addr_next, rsp_data_reg, rsp_data_next;
  logic [3:0] pend_reg, pend_next;
  logic write_reg, write_next, rsp_valid_reg, rsp_valid_next, atn_reg, atn_next;
  logic atn_n_reg;
  logic [1:0] region_reg, region_next;
  logic [31:0] dq_out_reg, dq_out_next, dq_oe_reg, dq_oe_next;
  logic [3:0] eff_be_n, hit;
  logic [1:0] cur_width;
  logic [31:0] read_lanes, write_lanes;
  logic data_access, rd_access, wr_access, finish, slot_free;

  // Steered read lanes
  lane_read_steer u_read_steer (
    .be_n(eff_be_n),
    .word(data_reg),
    .lanes(read_lanes)
  );

  always_comb begin
    cur_width = width_of(base_reg[region_reg]);
    eff_be_n = eff_enables(s_mode16, s_a1, s_be_n);
    case (cur_width)
      passthru_pkg::WIDTH_16: write_lanes = {s_dq[15:0], s_dq[15:0]};
      passthru_pkg::WIDTH_8: write_lanes = {4{s_dq[7:0]}};
      default: write_lanes = s_dq;
    endcase
    data_access = atn_reg && !s_sel_n && !s_addr_sel;
    rd_access = data_access && !s_rd_n;
    wr_access = data_access && !s_wr_n;
    // Completion needs a free response slot
    slot_free = !rsp_valid_reg || rsp_ready;
    // Phase waits on ready as long as the add-on needs
    finish = atn_reg && !s_ready_n && slot_free;
    hit = ~pend_reg & ~eff_be_n;
  end

  always_comb begin
    state_next = state_reg;
    data_next = data_reg;
    addr_next = addr_reg;
    pend_next = pend_reg;
    write_next = write_reg;
    region_next = region_reg;
    atn_next = atn_reg;
    rsp_valid_next = rsp_valid_reg && !rsp_ready;
    rsp_data_next = rsp_data_reg;
    fifo_pop = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (fifo_out_valid) begin
          fifo_pop = 1'b1;
          {write_next, region_next, pend_next, addr_next, data_next} = fifo_out;
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: begin
        atn_next = 1'b1;
        state_next = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (rd_access && write_reg) begin
          pend_next = pend_reg | ~eff_be_n;
        end
        if (wr_access && !write_reg) begin
          for (int i = 0; i < passthru_pkg::BE_W; i++) begin
            if (hit[i]) begin
              data_next[8*i +: 8] = write_lanes[8*i +: 8];
              pend_next[i] = 1'b1;
            end
          end
        end
        if (finish) begin
          atn_next = 1'b0;
          pend_next = passthru_pkg::PENDING_RESET;
          if (!write_reg) begin
            rsp_valid_next = 1'b1;
            rsp_data_next = data_next;
          end
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Add-on data bus drive
  always_comb begin
    dq_out_next = dq_out_reg;
    dq_oe_next = '0;
    if (atn_reg && !s_aoe_n) begin
      dq_out_next = addr_reg;
      dq_oe_next = drive_mask(s_mode16);
    end else if (atn_reg && !s_sel_n && !s_rd_n && s_addr_sel) begin
      dq_out_next = (s_mode16 && s_a1) ? {16'h0000, addr_reg[31:16]} : addr_reg;
      dq_oe_next = drive_mask(s_mode16);
    end else if (rd_access) begin
      dq_out_next = read_lanes;
      dq_oe_next = 32'hffff_ffff;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      data_reg <= passthru_pkg::DATA_RESET;
      addr_reg <= passthru_pkg::DATA_RESET;
      pend_reg <= passthru_pkg::PENDING_RESET;
      write_reg <= 1'b0;
      region_reg <= 2'h0;
      atn_reg <= 1'b0;
      atn_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      data_reg <= data_next;
      addr_reg <= addr_next;
      pend_reg <= pend_next;
      write_reg <= write_next;
      region_reg <= region_next;
      atn_reg <= atn_next;
      atn_n_reg <= !atn_next;
    end
  end

  // Response slot
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= passthru_pkg::DATA_RESET;
    end else begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
    end
  end

  // Add-on data bus registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_out_reg <= passthru_pkg::DATA_RESET;
      dq_oe_reg <= '0;
    end else begin
      dq_out_reg <= dq_out_next;
      dq_oe_reg <= dq_oe_next;
    end
  end

  // Region status registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_reg <= 4'h0;
      io_reg <= 4'h0;
      low_reg <= 4'h0;
      pf_reg <= 4'h0;
    end else begin
      en_reg <= en_next;
      io_reg <= io_next;
      low_reg <= low_next;
      pf_reg <= pf_next;
    end
  end

  assign dq_out = dq_out_reg;
  assign dq_oe = dq_oe_reg;
  assign access_attention_n = atn_n_reg;
  assign byte_pending_n = pend_reg;
  assign pass_write = write_reg;
  assign region_num = region_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign region_enabled = en_reg;
  assign region_is_io = io_reg;
  assign region_below_1m = low_reg;
  assign region_prefetch = pf_reg;
endmodule : passthru_lane_steer
`default_nettype wire

// File: core/passthru_pkg.sv
// Function
// - Each region has its own add-on width of 8, 16 or 32 bits.
// - In 16-bit mode the address bit one selects the byte enable half.
// - In 16-bit mode address output drives only the low 16 lines; address bit one selects the high half on address reads.
// - Read lanes: lowest enabled byte goes to bits 7:0, others shift as listed.
// - Read bits 31:24 always carry byte3; enable 0 gives natural lanes.
// - Reading with an enable asserted clears that byte's pending flag.
// - For PCI reads, pending flags equal the initiator's byte enables.
// - Write lanes steered by region width: own lane, 16-bit pairs, or low byte.
// - Byte n is written only when pending n and enable n are both active.
// - Each written byte clears its pending flag.
// - Enables sampled on each rising edge; a read clears matching pending flags.
// - Ready sampled active completes the phase once the response slot is free, drops attention, takes next data.
// - Bytes may be accessed in any order.
// - Selected byte stays on the bus while enables are unchanged.
// - Long add-on phases may cause retries on the PCI side.
// - Four region base registers, each one pass-through region.
// - Memory regions may be marked below 1 Mbyte and prefetchable.
// - Region base registers reset to zero, disabling each region.
// - Top two bits code width: 00 off, 01 8-bit, 10 16-bit, 11 32-bit.
// - Bit 0 selects memory (clear) or I/O (set) space.
package passthru_pkg;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int REGION_CNT = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_STAGES = 2;
  localparam int BASE_SPACE_BIT = 0;
  localparam int BASE_LOC_LO = 1;
  localparam int BASE_LOC_HI = 2;
  localparam int BASE_PREFETCH_BIT = 3;
  localparam int BASE_WIDTH_LO = 30;
  localparam int BASE_WIDTH_HI = 31;
  localparam logic [1:0] WIDTH_OFF = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic [1:0] WIDTH_32 = 2'h3;
  localparam logic [1:0] LOC_BELOW_1M = 2'h1;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [3:0] PENDING_RESET = 4'hf;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
endpackage : passthru_pkg

// File: verif/addon_model.sv
`timescale 1ns/1ps
`default_nettype none
module addon_model (
  input wire logic core_clk,
  output logic select_n,
  output logic rd_n,
  output logic wr_n,
  output logic [3:0] addon_byte_enable_n,
  output logic addon_ready_n,
  output logic [31:0] dq_in
);
  initial begin
    rel();
    addon_ready_n = 1'b1;
    dq_in = 32'h5a5a_5a5a;
  end
  // Strobe and enables held n cycles, bytes in any order
  task automatic access(input logic wr, input logic [3:0] be, input logic [31:0] d,
      input int n);
    @(negedge core_clk);
    select_n = 1'b0;
    rd_n = wr;
    wr_n = !wr;
    addon_byte_enable_n = be;
    dq_in = wr ? d : ~dq_in;
    repeat (n) @(negedge core_clk);
  endtask : access
  // Bus let go, data lines stop holding
  task automatic rel();
    select_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addon_byte_enable_n = 4'hf;
    dq_in = ~dq_in;
  endtask : rel
  // One-cycle ready once all flags are gone
  task automatic ready();
    addon_ready_n = 1'b0;
    @(negedge core_clk);
    addon_ready_n = 1'b1;
  endtask : ready
endmodule : addon_model
`default_nettype wire

// File: verif/passthru_lane_steer_props.sv
`timescale 1ns/1ps
`default_nettype none
module passthru_lane_steer_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic boot_valid,
  input wire logic [1:0] boot_index,
  input wire logic [31:0] boot_data,
  input wire logic mode_16bit,
  input wire logic [3:0] addon_byte_enable_n,
  input wire logic access_attention_n,
  input wire logic [3:0] byte_pending_n,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [31:0] rsp_data,
  input wire logic pass_write,
  input wire logic [1:0] region_num,
  input wire logic [3:0] region_enabled
);
  logic [1:0] bidx_q;
  logic ben_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bidx_q <= 2'h0;
      ben_q <= 1'b0;
    end else if (boot_valid) begin
      bidx_q <= boot_index;
      ben_q <= |boot_data[31:30];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  a_width_field_off: assert property (
      boot_valid |-> ##2 region_enabled[bidx_q] == ben_q)
    else $error("region enable wrong");
  a_pending_before_attn: assert property (
      $fell(access_attention_n) |-> $stable(byte_pending_n) && byte_pending_n != 4'hf)
    else $error("pending not loaded first");
  a_done_clears_all: assert property (
      $rose(access_attention_n) |-> byte_pending_n == 4'hf)
    else $error("pending left at finish");
  a_pending_only_clears: assert property (
      !access_attention_n && $past(!access_attention_n)
      |-> ($past(byte_pending_n) & ~byte_pending_n) == 4'h0)
    else $error("pending set mid phase");
  a_clear_needs_enable: assert property (
      !access_attention_n && !$past(mode_16bit, 3) |-> (byte_pending_n & ~$past(byte_pending_n)
      & $past(addon_byte_enable_n, 2) & $past(addon_byte_enable_n, 3)
      & $past(addon_byte_enable_n, 4)) == 4'h0)
    else $error("pending cleared without enable");
  a_rsp_word_holds: assert property (
      rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("response dropped");
  a_rsp_at_finish: assert property (
      $rose(rsp_valid) |-> $rose(access_attention_n))
    else $error("response off finish");
  a_phase_info_steady: assert property (
      !access_attention_n && $past(!access_attention_n) |-> $stable({pass_write, region_num}))
    else $error("phase info moved");
endmodule : passthru_lane_steer_props
bind passthru_lane_steer passthru_lane_steer_props u_props (.core_clk, .sys_rst, .boot_valid,
  .boot_index, .boot_data, .mode_16bit, .addon_byte_enable_n, .access_attention_n,
  .byte_pending_n, .rsp_valid, .rsp_ready, .rsp_data, .pass_write, .region_num, .region_enabled);
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic boot_valid = 1'b0;
  logic [1:0] boot_index = 2'h0;
  logic [31:0] boot_data = 32'h0;
  logic phase_valid = 1'b0;
  logic phase_is_write = 1'b0;
  logic [1:0] phase_region = 2'h0;
  logic [3:0] phase_byte_enable_n = 4'hf;
  logic [31:0] phase_address = 32'h0;
  logic [31:0] phase_data = 32'h0;
  logic rsp_ready = 1'b0;
  logic mode_16bit = 1'b0;
  logic addr_word_sel = 1'b0;
  logic addr_bit_one = 1'b0;
  logic pt_address_output_enable_n = 1'b1;
  logic select_n, rd_n, wr_n, addon_ready_n, phase_ready, rsp_valid, access_attention_n;
  logic pass_write;
  logic [1:0] region_num;
  logic [3:0] addon_byte_enable_n, byte_pending_n, region_enabled, region_is_io;
  logic [3:0] region_below_1m, region_prefetch;
  logic [31:0] dq_in, rsp_data, dq_out, dq_oe;
  logic [38:0] q[$];
  int fails = 0;
  int checked = 0;
  int seed = 13877;
  always #50 core_clk = ~core_clk;
  passthru_lane_steer u_dut (.core_clk, .sys_rst, .boot_valid, .boot_index, .boot_data,
    .phase_valid, .phase_ready, .phase_is_write, .phase_region, .phase_byte_enable_n,
    .phase_address, .phase_data, .rsp_valid, .rsp_ready, .rsp_data, .mode_16bit, .select_n,
    .rd_n, .wr_n, .addr_word_sel, .addr_bit_one, .addon_byte_enable_n,
    .pt_address_output_enable_n, .addon_ready_n, .dq_in, .dq_out, .dq_oe, .access_attention_n,
    .byte_pending_n, .pass_write, .region_num, .region_enabled, .region_is_io,
    .region_below_1m, .region_prefetch);
  addon_model u_addon (.core_clk, .select_n, .rd_n, .wr_n, .addon_byte_enable_n,
    .addon_ready_n, .dq_in);
  function automatic logic [31:0] lanes(input logic [3:0] be, input logic [31:0] w);
    if (!be[0]) return w;
    if (!be[1]) return {w[31:8], w[15:8]};
    if (!be[2]) return {w[31:16], w[31:16]};
    return {4{w[31:24]}};
  endfunction : lanes
  function automatic logic [31:0] steer(input logic [1:0] r, input logic [1:0] b,
      input logic [7:0] v, input logic [31:0] g);
    g[(r == 2'h2) ? 8 * b : (r == 2'h1) ? 8 * b[0] : 0 +: 8] = v;
    return g;
  endfunction : steer
  function automatic logic [38:0] newp();
    logic [31:0] k;
    k = $random(seed);
    return {k[0], 2'(k[2:1] % 2'h3), (k[7:4] == 4'hf) ? 4'h0 : k[7:4], 32'($random(seed))};
  endfunction : newp
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s exp %h got %h", name, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic push(input logic [38:0] p);
    @(negedge core_clk);
    {phase_is_write, phase_region, phase_byte_enable_n, phase_data} = p;
    phase_address = $random(seed);
    phase_valid = 1'b1;
    while (phase_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    phase_valid = 1'b0;
    q.push_back(p);
  endtask : push
  task automatic serve();
    logic [38:0] p;
    logic [31:0] w, k, m;
    logic [3:0] left;
    int n;
    p = q.pop_front();
    w = 32'h0;
    left = ~p[35:32];
    m = {{8{!p[35]}}, {8{!p[34]}}, {8{!p[33]}}, {8{!p[32]}}};
    n = 0;
    while (access_attention_n !== 1'b0 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    chk("pending", 32'(p[35:32]), 32'(byte_pending_n));
    chk("phase", 32'(p[38:36]), 32'({pass_write, region_num}));
    if (!p[38] && p[37:36] == 2'h2) begin
      w = $random(seed);
      u_addon.access(1'b1, 4'h0, w, 5);
      left = 4'h0;
    end
    while (left != 4'h0) begin
      k = $random(seed);
      if (left[k[1:0]]) begin
        left[k[1:0]] = 1'b0;
        if (p[38]) begin
          u_addon.access(1'b0, ~(4'h1 << k[1:0]), 32'h0, 5 + k[4:2]);
          chk("lanes", lanes(~(4'h1 << k[1:0]), p[31:0]), dq_out);
          chk("rd_clear", 32'h1, 32'(byte_pending_n[k[1:0]]));
        end else begin
          w[8 * k[1:0] +: 8] = k[15:8];
          u_addon.access(1'b1, ~(4'h1 << k[1:0]), steer(p[37:36], k[1:0], k[15:8], k), 5);
          chk("wr_clear", 32'h1, 32'(byte_pending_n[k[1:0]]));
        end
      end
    end
    u_addon.rel();
    repeat (3) @(negedge core_clk);
    chk("all_clear", 32'hf, 32'(byte_pending_n));
    u_addon.ready();
    n = 0;
    while (access_attention_n !== 1'b1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    chk("attn_done", 32'h1, 32'(access_attention_n));
    if (!p[38]) begin
      repeat (2) @(negedge core_clk);
      chk("rsp_valid", 32'h1, 32'(rsp_valid));
      chk("rsp_data", w & m, rsp_data & m);
      rsp_ready = 1'b1;
      @(negedge core_clk);
      rsp_ready = 1'b0;
    end
  endtask : serve
  task automatic serve16();
    logic [38:0] p;
    p = q.pop_front();
    repeat (4) @(negedge core_clk);
    pt_address_output_enable_n = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("addr_low", {16'h0, phase_address[15:0]}, dq_out & dq_oe);
    chk("addr_oe", 32'h0000_ffff, dq_oe);
    pt_address_output_enable_n = 1'b1;
    addr_word_sel = 1'b1;
    addr_bit_one = 1'b1;
    u_addon.access(1'b0, 4'hf, 32'h0, 5);
    chk("addr_high", {16'h0, phase_address[31:16]}, dq_out & dq_oe);
    addr_word_sel = 1'b0;
    addr_bit_one = 1'b0;
    u_addon.access(1'b0, 4'hc, 32'h0, 5);
    chk("lanes16_lo", {16'h0, p[15:0]}, dq_out & 32'h0000_ffff);
    addr_bit_one = 1'b1;
    u_addon.access(1'b0, 4'h3, 32'h0, 5);
    chk("lanes16_hi", {16'h0, p[31:16]}, dq_out & 32'h0000_ffff);
    u_addon.rel();
    repeat (3) @(negedge core_clk);
    chk("all_clear16", 32'hf, 32'(byte_pending_n));
    u_addon.ready();
    repeat (4) @(negedge core_clk);
    chk("attn_done16", 32'h1, 32'(access_attention_n));
    addr_bit_one = 1'b0;
  endtask : serve16
  initial begin
    int n;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    chk("reset", 32'h1f, {23'h0, region_enabled, byte_pending_n, access_attention_n});
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      boot_valid = 1'b1;
      boot_index = 2'(i);
      boot_data = (i == 0) ? 32'h4000_0008 : (i == 1) ? 32'h8000_0002 :
        (i == 2) ? 32'hc000_0001 : 32'h3fff_ffff;
      @(negedge core_clk);
      boot_valid = 1'b0;
      repeat (3) @(negedge core_clk);
    end
    chk("regions", 32'h7421, {16'h0, region_enabled, 1'b0, region_is_io[2:0], 1'b0,
      region_below_1m[2:0], 1'b0, region_prefetch[2:0]});
    $display("boot test done");
    push({1'b1, 2'h0, 4'h0, 32'h08d4_9a30});
    serve();
    push({1'b0, 2'h0, 4'hb, 32'h0});
    serve();
    for (int i = 0; i < 24; i++) begin
      push(newp());
      serve();
    end
    $display("single phase test done");
    n = 0;
    while (phase_ready === 1'b1 && n < 20) begin
      push(newp());
      n++;
    end
    chk("fill", 32'h1, 32'(n >= 16));
    while (q.size() > 0) serve();
    chk("drained", 32'h1, 32'(phase_ready));
    $display("fill test done");
    mode_16bit = 1'b1;
    push({1'b1, 2'h1, 4'h0, 32'h5e3c_a719});
    serve16();
    mode_16bit = 1'b0;
    $display("sixteen bit test done");
    stop_test();
  end
  initial begin
    #2000000;
    fails++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
